/* File: include/t2w_pkg.sv */
`default_nettype none
package t2w_pkg;

  // ==========================================================
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'hB0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hB1;
  localparam logic [7:0] ADDR_COUNT = 8'hB2;
  localparam logic [7:0] ADDR_CMP_A = 8'hB3;
  localparam logic [7:0] ADDR_CMP_B = 8'hB4;
  localparam logic [7:0] ADDR_INT_STAT = 8'hB5;
  localparam logic [7:0] ADDR_INT_MASK = 8'hB6;
  localparam logic [7:0] ADDR_PORT_DIR = 8'hB7;
  localparam logic [7:0] ADDR_PORT_DATA = 8'hB8;

  // ==========================================================
  // field positions
  localparam int COM_A_HI = 7;
  localparam int COM_A_LO = 6;
  localparam int COM_B_HI = 5;
  localparam int COM_B_LO = 4;
  localparam int WGM_HI = 1;
  localparam int WGM_LO = 0;
  localparam int CTRL_B_WGM_TOP = 3;
  localparam int CTRL_B_RUN = 0;
  localparam int INT_OVF = 0;
  localparam int INT_MATCH_A = 1;
  localparam int INT_MATCH_B = 2;
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;

  // ==========================================================
  // reset values and read masks
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] INT_RESET = 3'h0;
  localparam logic [1:0] PIN_RESET = 2'h0;
  localparam logic [7:0] CTRL_A_RD_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_RD_MASK = 8'h09;

  // ==========================================================
  // counter limits
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;

  // ==========================================================
  // waveform mode codes and output mode codes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PHASE_FF = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PHASE_CMP = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic [3:0] {
    T2W_NORMAL = 4'h1,
    T2W_CTC = 4'h2,
    T2W_FAST = 4'h4,
    T2W_PHASE = 4'h8
  } t2w_mode_type;

  typedef struct packed {
    logic level;
    logic drive_en;
  } t2w_pin_type;

endpackage
`default_nettype wire

/* File: logic/t2w_timer2_wave.sv */
// Overview of operation
// - nonzero output mode field hands the pin from port logic to compare output, except PWM A code 01 with top mode bit 0
// - pin driver enabled only while the direction bit for that pin is set
// - non-PWM channel A: off, toggle, clear, set on compare match
// - non-PWM channel B uses the same four codes as channel A
// - fast PWM A: 10 clear on match set at bottom, 11 inverse
// - PWM A code 01: off when top mode bit 0, toggle when it is 1
// - fast PWM, compare equals TOP with upper bit: skip match, act at bottom
// - phase PWM A: 10 clear on up match, set on down match; 11 inverse
// - phase PWM, compare equals TOP with upper bit: skip match, act at TOP
// - fast PWM B: 10 non-inverting, 11 inverting, 01 reserved
// - phase PWM B: 10 clear up, set down; 11 inverse; 01 reserved
// - the two unused control bits always read as zero
// - three-bit waveform mode joins the top bit and the two low bits
// - mode 0 top 0xFF, mode 2 top compare A; immediate update, flag at MAX
// - phase modes update at TOP flag at BOTTOM; fast update at BOTTOM
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module t2w_timer2_wave
  import t2w_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  // compare output pins
  output t2w_pin_type chan_a_compare_output,
  output t2w_pin_type chan_b_compare_output,
  // interrupt
  output logic irq
);

  // ==========================================================
  // registers
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] count_q, count_d;
  logic count_up_q, count_up_d;
  logic [7:0] cmp_a_buf_q, cmp_b_buf_q;
  logic [7:0] cmp_a_q, cmp_a_d, cmp_b_q, cmp_b_d;
  logic block_q;
  logic [2:0] int_stat_q, int_stat_d;
  logic [2:0] int_mask_q;
  logic [1:0] port_dir_q, port_data_q;
  logic wave_a_q, wave_a_d, wave_b_q, wave_b_d;
  logic [7:0] rd_data_q, rd_data_d;
  t2w_pin_type pin_a_q, pin_a_d, pin_b_q, pin_b_d;
  logic irq_q;

  // ==========================================================
  // address decode
  wire sel_ctrl_a = (addr == ADDR_CTRL_A);
  wire sel_ctrl_b = (addr == ADDR_CTRL_B);
  wire sel_count = (addr == ADDR_COUNT);
  wire sel_cmp_a = (addr == ADDR_CMP_A);
  wire sel_cmp_b = (addr == ADDR_CMP_B);
  wire sel_stat = (addr == ADDR_INT_STAT);
  wire sel_mask = (addr == ADDR_INT_MASK);
  wire sel_dir = (addr == ADDR_PORT_DIR);
  wire sel_data = (addr == ADDR_PORT_DATA);

  wire wr_ctrl_a = wr_en && sel_ctrl_a;
  wire wr_ctrl_b = wr_en && sel_ctrl_b;
  wire wr_count = wr_en && sel_count;
  wire wr_cmp_a = wr_en && sel_cmp_a;
  wire wr_cmp_b = wr_en && sel_cmp_b;
  wire wr_stat = wr_en && sel_stat;
  wire wr_mask = wr_en && sel_mask;
  wire wr_dir = wr_en && sel_dir;
  wire wr_data_reg = wr_en && sel_data;

  // ==========================================================
  // field extraction
  wire [1:0] com_a = ctrl_a_q[COM_A_HI:COM_A_LO];
  wire [1:0] com_b = ctrl_a_q[COM_B_HI:COM_B_LO];
  wire wgm_top_bit = ctrl_b_q[CTRL_B_WGM_TOP];
  wire [2:0] wgm = {wgm_top_bit, ctrl_a_q[WGM_HI:WGM_LO]};
  wire tick = ctrl_b_q[CTRL_B_RUN];

  // ==========================================================
  // mode decode
  t2w_mode_type mode_cls;
  logic top_is_cmp;
  always_comb begin
    mode_cls = T2W_NORMAL;
    top_is_cmp = 1'b0;
    case (wgm)
      WGM_NORMAL: mode_cls = T2W_NORMAL;
      WGM_CTC: begin
        mode_cls = T2W_CTC;
        top_is_cmp = 1'b1;
      end
      WGM_PHASE_FF: mode_cls = T2W_PHASE;
      WGM_PHASE_CMP: begin
        mode_cls = T2W_PHASE;
        top_is_cmp = 1'b1;
      end
      WGM_FAST_FF: mode_cls = T2W_FAST;
      WGM_FAST_CMP: begin
        mode_cls = T2W_FAST;
        top_is_cmp = 1'b1;
      end
      // reserved codes fall back to a plain free-running count
      default: mode_cls = T2W_NORMAL;
    endcase
  end

  wire is_pwm = (mode_cls == T2W_FAST) || (mode_cls == T2W_PHASE);
  wire [7:0] top_val = top_is_cmp ? cmp_a_q : CNT_MAX;
  wire at_top = (count_q == top_val);
  wire at_bottom = (count_q == CNT_BOTTOM);
  wire at_max = (count_q == CNT_MAX);

  // ==========================================================
  // count sequence
  wire up_wrap = (mode_cls != T2W_PHASE) && at_top;
  wire phase_turn_top = (mode_cls == T2W_PHASE) && count_up_q && at_top;
  wire phase_turn_bot = (mode_cls == T2W_PHASE) && !count_up_q && at_bottom;

  always_comb begin
    count_d = count_q;
    count_up_d = count_up_q;
    if (wr_count) begin
      count_d = wr_data;
    end else if (tick) begin
      if (mode_cls == T2W_PHASE) begin
        if (phase_turn_top) begin
          count_up_d = 1'b0;
          count_d = count_q - CNT_STEP;
        end else if (phase_turn_bot) begin
          count_up_d = 1'b1;
          count_d = count_q + CNT_STEP;
        end else if (count_up_q) begin
          count_d = count_q + CNT_STEP;
        end else begin
          count_d = count_q - CNT_STEP;
        end
      end else begin
        count_up_d = 1'b1;
        count_d = up_wrap ? CNT_BOTTOM : count_q + CNT_STEP;
      end
    end
  end

  // ==========================================================
  // compare value double buffer
  // PWM modes latch the buffer only at the sequence turn, so a new
  // duty cycle never produces a glitch mid-period
  wire fast_bottom = (mode_cls == T2W_FAST) && up_wrap;
  logic cmp_update;
  always_comb begin
    cmp_update = 1'b1;
    if (mode_cls == T2W_FAST) begin
      cmp_update = tick && fast_bottom;
    end else if (mode_cls == T2W_PHASE) begin
      cmp_update = tick && phase_turn_top;
    end
  end
  assign cmp_a_d = cmp_update ? cmp_a_buf_q : cmp_a_q;
  assign cmp_b_d = cmp_update ? cmp_b_buf_q : cmp_b_q;

  // ==========================================================
  // events
  // a counter write suppresses the match on the next tick
  wire match_a = tick && !block_q && (count_q == cmp_a_q);
  wire match_b = tick && !block_q && (count_q == cmp_b_q);
  logic ovf;
  always_comb begin
    ovf = 1'b0;
    case (mode_cls)
      T2W_NORMAL: ovf = tick && at_max;
      T2W_CTC: ovf = tick && at_max;
      T2W_FAST: ovf = tick && (top_is_cmp ? at_top : at_max);
      T2W_PHASE: ovf = tick && phase_turn_bot;
      default: ovf = 1'b0;
    endcase
  end

  // ==========================================================
  // waveform next state
  function automatic logic wave_next(
    input t2w_mode_type cls,
    input logic [1:0] com,
    input logic chan_is_a,
    input logic top_bit,
    input logic cur,
    input logic match,
    input logic bottom_ev,
    input logic top_ev,
    input logic up,
    input logic cmp_is_top
  );
    logic nxt;
    logic skip;
    nxt = cur;
    skip = cmp_is_top && com[1];
    case (cls)
      T2W_FAST: begin
        if (com == COM_TOGGLE) begin
          // the toggle code only exists on channel A with top bit set
          if (chan_is_a && top_bit && match) begin
            nxt = !cur;
          end
        end else if (com[1]) begin
          if (bottom_ev) begin
            nxt = (com == COM_CLEAR);
          end else if (match && !skip) begin
            nxt = (com == COM_SET);
          end
        end
      end
      T2W_PHASE: begin
        if (com == COM_TOGGLE) begin
          if (chan_is_a && top_bit && match) begin
            nxt = !cur;
          end
        end else if (com[1]) begin
          if (skip) begin
            if (top_ev) begin
              nxt = (com == COM_CLEAR);
            end
          end else if (match) begin
            // up-count match gives the code's primary action
            nxt = up ? (com == COM_SET) : (com == COM_CLEAR);
          end
        end
      end
      default: begin
        if (match) begin
          case (com)
            COM_TOGGLE: nxt = !cur;
            COM_CLEAR: nxt = 1'b0;
            COM_SET: nxt = 1'b1;
            default: nxt = cur;
          endcase
        end
      end
    endcase
    return nxt;
  endfunction

  wire bottom_ev = tick && fast_bottom;
  wire top_ev = tick && phase_turn_top;
  wire cmp_a_top = is_pwm && (cmp_a_q == top_val);
  wire cmp_b_top = is_pwm && (cmp_b_q == top_val);

  assign wave_a_d = wave_next(mode_cls, com_a, 1'b1, wgm_top_bit, wave_a_q,
    match_a, bottom_ev, top_ev, count_up_q, cmp_a_top);
  assign wave_b_d = wave_next(mode_cls, com_b, 1'b0, wgm_top_bit, wave_b_q,
    match_b, bottom_ev, top_ev, count_up_q, cmp_b_top);

  // ==========================================================
  // pin override
  // channel A code 01 in PWM with top bit clear stays disconnected
  wire a_pwm_off = is_pwm && (com_a == COM_TOGGLE) && !wgm_top_bit;
  wire own_a = (com_a != COM_OFF) && !a_pwm_off;
  wire own_b = (com_b != COM_OFF);
  assign pin_a_d.level = own_a ? wave_a_d : port_data_q[PIN_A];
  assign pin_b_d.level = own_b ? wave_b_d : port_data_q[PIN_B];
  assign pin_a_d.drive_en = port_dir_q[PIN_A];
  assign pin_b_d.drive_en = port_dir_q[PIN_B];

  // ==========================================================
  // interrupt status, set beats a same-cycle clear
  wire [2:0] int_set = {match_b, match_a, ovf};
  wire [2:0] int_clr = wr_stat ? wr_data[2:0] : 3'h0;
  assign int_stat_d = (int_stat_q & ~int_clr) | int_set;

  // ==========================================================
  // read mux
  always_comb begin
    rd_data_d = BYTE_RESET;
    if (!rd_en) begin
      rd_data_d = BYTE_RESET;
    end else if (sel_ctrl_a) begin
      rd_data_d = ctrl_a_q & CTRL_A_RD_MASK;
    end else if (sel_ctrl_b) begin
      rd_data_d = ctrl_b_q & CTRL_B_RD_MASK;
    end else if (sel_count) begin
      rd_data_d = count_q;
    end else if (sel_cmp_a) begin
      rd_data_d = cmp_a_buf_q;
    end else if (sel_cmp_b) begin
      rd_data_d = cmp_b_buf_q;
    end else if (sel_stat) begin
      rd_data_d = {5'h00, int_stat_q};
    end else if (sel_mask) begin
      rd_data_d = {5'h00, int_mask_q};
    end else if (sel_dir) begin
      rd_data_d = {6'h00, port_dir_q};
    end else if (sel_data) begin
      rd_data_d = {6'h00, port_data_q};
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_q <= CTRL_A_RESET;
      ctrl_b_q <= CTRL_B_RESET;
      int_mask_q <= INT_RESET;
      port_dir_q <= PIN_RESET;
      port_data_q <= PIN_RESET;
      cmp_a_buf_q <= BYTE_RESET;
      cmp_b_buf_q <= BYTE_RESET;
    end else begin
      if (wr_ctrl_a) ctrl_a_q <= wr_data & CTRL_A_RD_MASK;
      if (wr_ctrl_b) ctrl_b_q <= wr_data & CTRL_B_RD_MASK;
      if (wr_mask) int_mask_q <= wr_data[2:0];
      if (wr_dir) port_dir_q <= wr_data[1:0];
      if (wr_data_reg) port_data_q <= wr_data[1:0];
      if (wr_cmp_a) cmp_a_buf_q <= wr_data;
      if (wr_cmp_b) cmp_b_buf_q <= wr_data;
    end
  end

  // ==========================================================
  // counter and compare state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= BYTE_RESET;
      count_up_q <= 1'b1;
      cmp_a_q <= BYTE_RESET;
      cmp_b_q <= BYTE_RESET;
      block_q <= 1'b0;
    end else begin
      count_q <= count_d;
      count_up_q <= count_up_d;
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
      block_q <= wr_count ? 1'b1 : (tick ? 1'b0 : block_q);
    end
  end

  // ==========================================================
  // waveform, pins, flags, read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      pin_a_q <= '0;
      pin_b_q <= '0;
      int_stat_q <= INT_RESET;
      irq_q <= 1'b0;
      rd_data_q <= BYTE_RESET;
    end else begin
      wave_a_q <= wave_a_d;
      wave_b_q <= wave_b_d;
      pin_a_q <= pin_a_d;
      pin_b_q <= pin_b_d;
      int_stat_q <= int_stat_d;
      irq_q <= |(int_stat_d & int_mask_q);
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;
  assign chan_a_compare_output = pin_a_q;
  assign chan_b_compare_output = pin_b_q;
  assign irq = irq_q;

endmodule
`default_nettype wire

/* File: sim/t2w_timer2_wave_props.sv */
`timescale 1ns/1ps
`default_nettype none
module t2w_props
  import t2w_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  // pins and interrupt
  input wire t2w_pin_type chan_a_compare_output,
  input wire t2w_pin_type chan_b_compare_output,
  input wire logic irq
);
  // ==========================================================
  // shadow registers
  logic [7:0] ca_q, cb_q, cpa_q, cpb_q, msk_q, dir_q, pd_q;
  // cycles since the last write, saturating; pins need two to settle
  logic [9:0] quiet_q;
  wire logic [2:0] mode = {cb_q[CTRL_B_WGM_TOP], ca_q[WGM_HI:WGM_LO]};
  wire logic calm = quiet_q > 10'd2;
  wire logic run = cb_q[CTRL_B_RUN];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_q <= 10'h000;
      ca_q <= 8'h00;
      cb_q <= 8'h00;
      cpa_q <= 8'h00;
      cpb_q <= 8'h00;
      msk_q <= 8'h00;
      dir_q <= 8'h00;
      pd_q <= 8'h00;
    end else begin
      quiet_q <= wr_en ? 10'h000 : quiet_q + {9'h000, ~&quiet_q};
      if (wr_en) begin
        case (addr)
          ADDR_CTRL_A: ca_q <= wr_data;
          ADDR_CTRL_B: cb_q <= wr_data;
          ADDR_CMP_A: cpa_q <= wr_data;
          ADDR_CMP_B: cpb_q <= wr_data;
          ADDR_INT_MASK: msk_q <= wr_data;
          ADDR_PORT_DIR: dir_q <= wr_data;
          ADDR_PORT_DATA: pd_q <= wr_data;
          default: ;
        endcase
      end
    end
  end
  // ==========================================================
  // properties
  default clocking dclk @(posedge clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data not zero outside a read");
  AST_RES_BITS: assert property (rd_en && addr == ADDR_CTRL_A |=>
    rd_data[3:2] == 2'h0) else $error("unused control bits read one");
  AST_CTRL_RB: assert property (rd_en && addr == ADDR_CTRL_A |=>
    rd_data == (ca_q & 8'hF3)) else $error("control readback wrong");
  AST_UNMAPPED: assert property (rd_en && (addr < ADDR_CTRL_A ||
    addr > ADDR_PORT_DATA) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  AST_DRIVE: assert property (calm |->
    chan_a_compare_output.drive_en == dir_q[PIN_A] &&
    chan_b_compare_output.drive_en == dir_q[PIN_B])
    else $error("pin driver does not follow direction");
  AST_PORT_OFF: assert property (calm && ca_q[7:6] == COM_OFF |->
    chan_a_compare_output.level == pd_q[PIN_A])
    else $error("pin a not under port control");
  AST_PWM_A01: assert property (calm && !cb_q[CTRL_B_WGM_TOP] &&
    ca_q[0] && ca_q[7:6] == COM_TOGGLE |->
    chan_a_compare_output.level == pd_q[PIN_A])
    else $error("pin a taken over by code one in pwm");
  AST_STOP_HOLD: assert property (calm && !wr_en && !run |=>
    $stable(chan_a_compare_output.level) &&
    $stable(chan_b_compare_output.level))
    else $error("pin moved while counter stopped");
  AST_FAST_TOP: assert property (quiet_q > 10'd300 && run &&
    mode == WGM_FAST_FF && ca_q[5:4] == COM_CLEAR && cpb_q == CNT_MAX
    |-> chan_b_compare_output.level) else $error("fast top case low");
  // a TOP compare reaches the skip logic only after one turn has loaded
  // the buffer, so the forced level may take two full periods to show
  AST_PHASE_TOP: assert property (&quiet_q && run &&
    mode == WGM_PHASE_FF && ca_q[7:6] == COM_CLEAR && cpa_q == CNT_MAX
    |-> chan_a_compare_output.level) else $error("phase top case low");
  AST_IRQ_MASK: assert property (calm && msk_q == 8'h00 |-> !irq)
    else $error("interrupt with all sources masked");
  COV_CTRL_READ: cover property (rd_en && addr == ADDR_CTRL_A);
  COV_IRQ: cover property ($rose(irq));
  COV_PHASE_CMP: cover property (quiet_q > 10'd300 &&
    mode == WGM_PHASE_CMP);
endmodule

bind t2w_timer2_wave t2w_props u_props (.clk(clk), .rst(rst),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .chan_a_compare_output(chan_a_compare_output),
  .chan_b_compare_output(chan_b_compare_output), .irq(irq));
`default_nettype wire

/* File: sim/t2w_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import t2w_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  t2w_pin_type pin_a, pin_b;
  logic irq;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  wire logic [1:0] lvl = {pin_b.level, pin_a.level};
  wire logic [1:0] den = {pin_b.drive_en, pin_a.drive_en};
  // mode, output codes, compares (0 picks a random one), port data, dir
  int cm[9] = '{0, 2, 3, 3, 1, 1, 7, 5, 0};
  int coa[9] = '{1, 1, 2, 1, 3, 2, 1, 0, 0};
  int cob[9] = '{3, 1, 3, 2, 2, 3, 2, 3, 0};
  int cca[9] = '{0, 0, 0, 0, 0, 255, 0, 0, 0};
  int ccb[9] = '{0, 0, 0, 255, 0, 0, 0, 0, 0};
  int cpd[9] = '{0, 0, 0, 1, 0, 0, 0, 0, 3};
  int cdr[9] = '{3, 3, 3, 3, 3, 1, 2, 3, 0};

  always #20 clk = ~clk;

  t2w_timer2_wave dut (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .chan_a_compare_output(pin_a), .chan_b_compare_output(pin_b),
    .irq(irq));

  // ==========================================================
  // bus, check and report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end

  // ==========================================================
  // model: high samples and edges over two periods
  function automatic void model(input int m, com, c, tp, pd,
      input bit is_a, output int hi2, output int tg2);
    int per, h;
    per = (m == 1 || m == 5) ? 2 * tp : tp + 1;
    h = pd * per;
    if (com == 1 && (m == 0 || m == 2 || (m > 4 && is_a)))
      h = -1;
    else if (com > 1 && (m == 0 || m == 2))
      h = (com == 3) ? per : 0;
    else if (com > 1 && (m == 3 || m == 7))
      h = (c >= tp) ? per : c + 1;
    else if (com > 1)
      h = (c >= tp) ? per : 2 * c;
    if (com == 3 && m != 0 && m != 2)
      h = per - h;
    hi2 = (h < 0) ? per : 2 * h;
    tg2 = (h < 0) ? 2 : ((h > 0 && h < per) ? 4 : 0);
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d;
    int m, ca, cb, tp, per, e_hi, e_tg;
    int hi[2];
    int tg[2];
    logic [1:0] lastl;
    void'($urandom(1391));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL_A, d);
    chk("ctrl a reset", 16'h0000, 16'(d));
    wr(ADDR_CTRL_A, 8'hFF);
    rd(ADDR_CTRL_A, d);
    chk("ctrl a readback", 16'h00F3, 16'(d));
    rd(8'hC0, d);
    chk("unmapped read", 16'h0000, 16'(d));
    for (int i = 0; i < 9; i++) begin
      m = cm[i];
      ca = (cca[i] == 0) ? $urandom_range(200, 100) : cca[i];
      cb = (ccb[i] == 0) ? $urandom_range(90, 10) : ccb[i];
      tp = (m == 2 || m == 5 || m == 7) ? ca : 255;
      per = (m == 1 || m == 5) ? 2 * tp : tp + 1;
      wr(ADDR_CTRL_B, (m > 3) ? 8'h09 : 8'h01);
      wr(ADDR_CTRL_A, 8'((coa[i] << 6) | (cob[i] << 4) | (m % 4)));
      wr(ADDR_CMP_A, 8'(ca));
      wr(ADDR_CMP_B, 8'(cb));
      wr(ADDR_PORT_DIR, 8'(cdr[i]));
      wr(ADDR_PORT_DATA, 8'(cpd[i]));
      repeat (2 * per + 300) @(posedge clk);
      hi = '{0, 0};
      tg = '{0, 0};
      @(negedge clk);
      lastl = lvl;
      repeat (2 * per) begin
        @(negedge clk);
        for (int k = 0; k < 2; k++) begin
          hi[k] += (lvl[k] === 1'b1);
          tg[k] += (lvl[k] !== lastl[k]);
        end
        lastl = lvl;
      end
      for (int k = 0; k < 2; k++) begin
        model(m, k ? cob[i] : coa[i], k ? cb : ca, tp, (cpd[i] >> k) & 1,
          k == 0, e_hi, e_tg);
        chk("high samples", 16'(e_hi), 16'(hi[k]));
        chk("edges", 16'(e_tg), 16'(tg[k]));
        chk("drive enable", 16'((cdr[i] >> k) & 1), 16'(den[k]));
      end
    end
    wr(ADDR_INT_STAT, 8'h07);
    repeat (300) @(posedge clk);
    rd(ADDR_INT_STAT, d);
    chk("overflow flag", 16'h0001, 16'(d[INT_OVF]));
    chk("match flags", 16'h0003, 16'(d[INT_MATCH_B:INT_MATCH_A]));
    chk("irq masked", 16'h0000, 16'(irq));
    wr(ADDR_INT_MASK, 8'h01);
    repeat (3) @(negedge clk);
    chk("irq raised", 16'h0001, 16'(irq));
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_INT_STAT, 8'h07);
    repeat (3) @(negedge clk);
    chk("irq cleared", 16'h0000, 16'(irq));
    rd(ADDR_INT_STAT, d);
    chk("status cleared", 16'h0000, 16'(d));
    final_report();
  end
endmodule
`default_nettype wire
